// ### hw/spal_pkg.sv
// constants, register map and error codes of the servo protection alarm logic
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package spal_pkg;
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_HYB_LIM   = 8'h04;
	localparam logic [7:0]  ADDR_OVS_LVL   = 8'h08;
	localparam logic [7:0]  ADDR_MAX_SPD   = 8'h0C;
	localparam logic [7:0]  ADDR_SCL_NUM   = 8'h10;
	localparam logic [7:0]  ADDR_SCL_DEN   = 8'h14;
	localparam logic [7:0]  ADDR_TRAVEL    = 8'h18;
	localparam logic [7:0]  ADDR_GEAR1     = 8'h1C;
	localparam logic [7:0]  ADDR_GEAR2     = 8'h20;
	localparam logic [7:0]  ADDR_STATUS    = 8'h24;
	localparam logic [7:0]  ADDR_MASK      = 8'h28;
	localparam logic [7:0]  ADDR_ALARM     = 8'h2C;
	localparam logic [7:0]  ADDR_DISC_LIM  = 8'h30;
	// ctrl register fields
	localparam int          CTRL_FULL_CLOSED = 0;
	localparam int          CTRL_SCALE_INV   = 1;
	localparam int          CTRL_OT_MODE_LSB = 2;
	localparam int          CTRL_CLEAR       = 4;
	localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
	localparam logic [31:0] HYB_LIM_RESET    = 32'h0000_2710;
	localparam logic [31:0] MAX_SPD_RESET    = 32'h0000_1770;
	localparam logic [31:0] SCL_RATIO_RESET  = 32'h0000_0001;
	localparam logic [31:0] TRAVEL_RESET     = 32'h0000_2710;
	localparam logic [31:0] GEAR_RESET       = 32'h0001_0001;
	localparam logic [31:0] DISC_LIM_RESET   = 32'h0001_E848;
	localparam logic [63:0] DEV_LIMIT        = 64'h0000_0000_0800_0000;
	// gear word: numerator high half, denominator low half; ratio bounds
	localparam int          GEAR_MAX_MUL     = 4000;
	localparam int          GEAR_MIN_DIV     = 50;
	localparam int          NUM_EVT          = 10;
	localparam int          EV_HYB  = 0;
	localparam int          EV_OVS  = 1;
	localparam int          EV_GEAR = 2;
	localparam int          EV_SDAT = 3;
	localparam int          EV_DOVF = 4;
	localparam int          EV_SOFT = 5;
	localparam int          EV_SDIS = 6;
	localparam int          EV_PARM = 7;
	localparam int          EV_CHK  = 8;
	localparam int          EV_OT   = 9;
	localparam logic [7:0]  ERR_NONE = 8'h00;
	localparam logic [7:0]  ERR_HYB  = 8'h19;
	localparam logic [7:0]  ERR_OVS  = 8'h1A;
	localparam logic [7:0]  ERR_GEAR = 8'h1B;
	localparam logic [7:0]  ERR_SDAT = 8'h1C;
	localparam logic [7:0]  ERR_DOVF = 8'h1D;
	localparam logic [7:0]  ERR_SOFT = 8'h22;
	localparam logic [7:0]  ERR_SDIS = 8'h23;
	localparam logic [7:0]  ERR_PARM = 8'h24;
	localparam logic [7:0]  ERR_CHK  = 8'h25;
	localparam logic [7:0]  ERR_OT   = 8'h26;
	localparam logic [1:0]  OT_MODE_BOTH   = 2'h0;
	localparam logic [1:0]  OT_MODE_EITHER = 2'h2;
	localparam int          SYNC_STAGES    = 3;
endpackage

// ### hw/spal_top.sv
// servo protection alarm logic with apb register slave
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module spal_top
(
	input  wire logic               clk_sys,
	input  wire logic               sys_rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic signed [31:0] motor_pos,
	input  wire logic signed [31:0] scale_pos,
	input  wire logic        [31:0] motor_speed,
	input  wire logic signed [31:0] deviation_count,
	input  wire logic               scale_frame,
	input  wire logic               scale_frame_err,
	input  wire logic               scale_cable_ok,
	input  wire logic               nvm_check_done,
	input  wire logic               nvm_param_bad,
	input  wire logic               nvm_code_bad,
	input  wire logic               fwd_travel_inhibit_open,
	input  wire logic               rev_travel_inhibit_open,
	output logic                    alarm,
	output logic      [7:0]         error_code,
	output logic                    run_enable,
	output logic                    irq
);
	logic [31:0] ctrl;
	logic [31:0] hybrid_deviation_limit;
	logic [31:0] overspeed_level;
	logic [31:0] max_speed;
	logic [31:0] scale_num;
	logic [31:0] scale_den;
	logic [31:0] soft_travel_range;
	logic [31:0] gear1;
	logic [31:0] gear2;
	logic [31:0] disc_limit;
	logic [spal_pkg::NUM_EVT-1:0] status;
	logic [spal_pkg::NUM_EVT-1:0] mask;
	logic [spal_pkg::NUM_EVT-1:0] evt;
	logic [spal_pkg::NUM_EVT-1:0] clr_w1;
	logic [31:0] disc_cnt;
	logic        nvm_seen;
	logic [spal_pkg::SYNC_STAGES-1:0] fwd_sync;
	logic [spal_pkg::SYNC_STAGES-1:0] rev_sync;
	logic        fwd_open;
	logic        rev_open;
	logic        wr_acc;
	logic [7:0]  next_error_code;
	logic [31:0] next_prdata;

	// ------------------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------------------
	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_acc = psel & penable & pwrite;

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a <= spal_pkg::ADDR_DISC_LIM) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic gear_bad(input logic [31:0] g);
		logic [31:0] num;
		logic [31:0] den;
		num = {16'h0000, g[31:16]};
		den = {16'h0000, g[15:0]};
		gear_bad = (den == 32'h0000_0000) || (num == 32'h0000_0000)
			|| (num > den * 32'(spal_pkg::GEAR_MAX_MUL))
			|| (num * 32'(spal_pkg::GEAR_MIN_DIV) < den);
	endfunction

	assign pslverr = psel & penable & ~known_addr(paddr);

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			ctrl                   <= spal_pkg::CTRL_RESET;
			hybrid_deviation_limit <= spal_pkg::HYB_LIM_RESET;
			overspeed_level        <= 32'h0000_0000;
			max_speed              <= spal_pkg::MAX_SPD_RESET;
			scale_num              <= spal_pkg::SCL_RATIO_RESET;
			scale_den              <= spal_pkg::SCL_RATIO_RESET;
			soft_travel_range      <= spal_pkg::TRAVEL_RESET;
			gear1                  <= spal_pkg::GEAR_RESET;
			gear2                  <= spal_pkg::GEAR_RESET;
			disc_limit             <= spal_pkg::DISC_LIM_RESET;
			mask                   <= '0;
		end
		else
		begin
			ctrl[spal_pkg::CTRL_CLEAR] <= 1'b0;
			if (wr_acc)
			begin
				case (paddr)
					spal_pkg::ADDR_CTRL:     ctrl <= pwdata;
					spal_pkg::ADDR_HYB_LIM:  hybrid_deviation_limit <= pwdata;
					spal_pkg::ADDR_OVS_LVL:  overspeed_level <= pwdata;
					spal_pkg::ADDR_MAX_SPD:  max_speed <= pwdata;
					spal_pkg::ADDR_SCL_NUM:  scale_num <= pwdata;
					spal_pkg::ADDR_SCL_DEN:  scale_den <= pwdata;
					spal_pkg::ADDR_TRAVEL:   soft_travel_range <= pwdata;
					spal_pkg::ADDR_GEAR1:    gear1 <= pwdata;
					spal_pkg::ADDR_GEAR2:    gear2 <= pwdata;
					spal_pkg::ADDR_MASK:     mask <= pwdata[spal_pkg::NUM_EVT-1:0];
					spal_pkg::ADDR_DISC_LIM: disc_limit <= pwdata;
					default:                 ;
				endcase
			end
		end
	end

	always_comb
	begin
		case (paddr)
			spal_pkg::ADDR_CTRL:     next_prdata = ctrl;
			spal_pkg::ADDR_HYB_LIM:  next_prdata = hybrid_deviation_limit;
			spal_pkg::ADDR_OVS_LVL:  next_prdata = overspeed_level;
			spal_pkg::ADDR_MAX_SPD:  next_prdata = max_speed;
			spal_pkg::ADDR_SCL_NUM:  next_prdata = scale_num;
			spal_pkg::ADDR_SCL_DEN:  next_prdata = scale_den;
			spal_pkg::ADDR_TRAVEL:   next_prdata = soft_travel_range;
			spal_pkg::ADDR_GEAR1:    next_prdata = gear1;
			spal_pkg::ADDR_GEAR2:    next_prdata = gear2;
			spal_pkg::ADDR_STATUS:   next_prdata = 32'(status);
			spal_pkg::ADDR_MASK:     next_prdata = 32'(mask);
			spal_pkg::ADDR_ALARM:    next_prdata = {23'h000000, alarm, error_code};
			spal_pkg::ADDR_DISC_LIM: next_prdata = disc_limit;
			default:                 next_prdata = 32'h0000_0000;
		endcase
	end

	// read data registered during the setup cycle, valid in the access cycle
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite)
			prdata <= next_prdata;
	end

	// ------------------------------------------------------------------------
	// inhibit input synchronisers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			fwd_sync <= '0;
			rev_sync <= '0;
			fwd_open <= 1'b0;
			rev_open <= 1'b0;
		end
		else
		begin
			fwd_sync <= {fwd_sync[1:0], fwd_travel_inhibit_open};
			rev_sync <= {rev_sync[1:0], rev_travel_inhibit_open};
			if (fwd_sync[1] == fwd_sync[2])
				fwd_open <= fwd_sync[2];
			if (rev_sync[1] == rev_sync[2])
				rev_open <= rev_sync[2];
		end
	end

	// ------------------------------------------------------------------------
	// fault detection
	// ------------------------------------------------------------------------
	logic signed [63:0] scaled_scale;
	logic signed [63:0] hyb_diff;
	logic        [63:0] hyb_mag;
	logic        [63:0] ovs_thr;
	logic        [63:0] dev_mag;
	logic        [1:0]  ot_mode;

	always_comb
	begin
		// scale feedback brought to encoder units and sign
		scaled_scale = (64'(scale_pos) * $signed({32'h0000_0000, scale_num}))
			/ $signed({32'h0000_0000, (scale_den == 32'h0000_0000) ? 32'h0000_0001 : scale_den});
		if (ctrl[spal_pkg::CTRL_SCALE_INV])
			scaled_scale = -scaled_scale;
		hyb_diff = 64'(motor_pos) - scaled_scale;
		hyb_mag  = hyb_diff[63] ? 64'(-hyb_diff) : 64'(hyb_diff);
		// zero level selects 1.2 x maximum speed, computed as 6/5
		if (overspeed_level == 32'h0000_0000)
			ovs_thr = (64'(max_speed) * 64'h0000_0000_0000_0006) / 64'h0000_0000_0000_0005;
		else
			ovs_thr = 64'(overspeed_level);
		dev_mag = deviation_count[31] ? 64'(-64'(deviation_count)) : 64'(deviation_count);
		ot_mode = ctrl[spal_pkg::CTRL_OT_MODE_LSB +: 2];
	end

	// scale link watchdog: counts cycles since the last good or bad frame
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			disc_cnt <= 32'h0000_0000;
		else if (scale_frame | ~ctrl[spal_pkg::CTRL_FULL_CLOSED])
			disc_cnt <= 32'h0000_0000;
		else if (disc_cnt != 32'hFFFF_FFFF)
			disc_cnt <= disc_cnt + 32'h0000_0001;
	end

	// nvm faults sampled once, when the power-on check completes
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			nvm_seen <= 1'b0;
		else if (nvm_check_done)
			nvm_seen <= 1'b1;
	end

	always_comb
	begin
		evt = '0;
		evt[spal_pkg::EV_HYB]  = ctrl[spal_pkg::CTRL_FULL_CLOSED]
			& (hyb_mag > 64'(hybrid_deviation_limit));
		evt[spal_pkg::EV_OVS]  = 64'(motor_speed) > ovs_thr;
		evt[spal_pkg::EV_GEAR] = gear_bad(gear1) | gear_bad(gear2);
		evt[spal_pkg::EV_SDAT] = scale_frame & scale_frame_err & scale_cable_ok;
		evt[spal_pkg::EV_DOVF] = dev_mag > spal_pkg::DEV_LIMIT;
		evt[spal_pkg::EV_SOFT] = (motor_pos > $signed(soft_travel_range))
			| (motor_pos < -$signed(soft_travel_range));
		evt[spal_pkg::EV_SDIS] = ctrl[spal_pkg::CTRL_FULL_CLOSED] & (disc_cnt >= disc_limit);
		evt[spal_pkg::EV_PARM] = nvm_check_done & ~nvm_seen & nvm_param_bad;
		evt[spal_pkg::EV_CHK]  = nvm_check_done & ~nvm_seen & nvm_code_bad;
		evt[spal_pkg::EV_OT]   = ((ot_mode == spal_pkg::OT_MODE_BOTH) & fwd_open & rev_open)
			| ((ot_mode == spal_pkg::OT_MODE_EITHER) & (fwd_open | rev_open));
	end

	// ------------------------------------------------------------------------
	// sticky status, interrupt, alarm latch
	// ------------------------------------------------------------------------
	assign clr_w1 = (wr_acc && paddr == spal_pkg::ADDR_STATUS) ? pwdata[spal_pkg::NUM_EVT-1:0] : '0;

	genvar gi;
	generate
		for (gi = 0; gi < spal_pkg::NUM_EVT; gi++)
		begin : g_stat
			// a new event beats a write-one clear in the same cycle
			always_ff @(posedge clk_sys)
			begin
				if (sys_rst)
					status[gi] <= 1'b0;
				else if (evt[gi])
					status[gi] <= 1'b1;
				else if (clr_w1[gi])
					status[gi] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			irq <= 1'b0;
		else
			// a set mask bit keeps its event off irq; status and the alarm still latch it
			irq <= |(status & ~mask);
	end

	// first fault in priority order names the code
	always_comb
	begin
		next_error_code = spal_pkg::ERR_NONE;
		if (evt[spal_pkg::EV_PARM])      next_error_code = spal_pkg::ERR_PARM;
		else if (evt[spal_pkg::EV_CHK])  next_error_code = spal_pkg::ERR_CHK;
		else if (evt[spal_pkg::EV_GEAR]) next_error_code = spal_pkg::ERR_GEAR;
		else if (evt[spal_pkg::EV_OVS])  next_error_code = spal_pkg::ERR_OVS;
		else if (evt[spal_pkg::EV_DOVF]) next_error_code = spal_pkg::ERR_DOVF;
		else if (evt[spal_pkg::EV_HYB])  next_error_code = spal_pkg::ERR_HYB;
		else if (evt[spal_pkg::EV_SDIS]) next_error_code = spal_pkg::ERR_SDIS;
		else if (evt[spal_pkg::EV_SDAT]) next_error_code = spal_pkg::ERR_SDAT;
		else if (evt[spal_pkg::EV_SOFT]) next_error_code = spal_pkg::ERR_SOFT;
		else if (evt[spal_pkg::EV_OT])   next_error_code = spal_pkg::ERR_OT;
	end

	// alarm holds its first code; clear is refused while a fault persists
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			alarm      <= 1'b0;
			error_code <= spal_pkg::ERR_NONE;
			run_enable <= 1'b0;
		end
		else if (!alarm && next_error_code != spal_pkg::ERR_NONE)
		begin
			alarm      <= 1'b1;
			error_code <= next_error_code;
			run_enable <= 1'b0;
		end
		else if (alarm && ctrl[spal_pkg::CTRL_CLEAR] && evt == '0)
		begin
			alarm      <= 1'b0;
			error_code <= spal_pkg::ERR_NONE;
			run_enable <= 1'b1;
		end
		else if (!alarm)
			run_enable <= 1'b1;
	end
endmodule

// ### test/spal_props.sv
// assertion checker bound to the protection alarm logic
`timescale 1ns/10ps
module spal_props
(
	input wire logic               clk_sys,
	input wire logic               sys_rst,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic        [7:0]  paddr,
	input wire logic               pslverr,
	input wire logic signed [31:0] deviation_count,
	input wire logic               scale_frame,
	input wire logic               scale_frame_err,
	input wire logic               scale_cable_ok,
	input wire logic               nvm_check_done,
	input wire logic               nvm_param_bad,
	input wire logic               fwd_travel_inhibit_open,
	input wire logic               rev_travel_inhibit_open,
	input wire logic               alarm,
	input wire logic        [7:0]  error_code,
	input wire logic               run_enable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	AST_RUN_OFF: assert property (alarm |-> !run_enable) else $error("run enable during alarm");
	AST_RUN_ON: assert property ((!sys_rst && !alarm) ##1 !alarm |-> run_enable) else $error("run enable low");
	AST_CODE: assert property (alarm && $past(alarm) |-> $stable(error_code)) else $error("code moved");
	AST_DOVF: assert property (deviation_count > 32'sh0800_0000 || deviation_count < -32'sh0800_0000 |=> alarm)
		else $error("no overflow alarm");
	AST_SDAT: assert property (scale_frame && scale_frame_err && scale_cable_ok |=> alarm)
		else $error("no scale data alarm");
	AST_NVM: assert property ($rose(nvm_check_done) && nvm_param_bad && !alarm |=> error_code == 8'h24)
		else $error("no stored data alarm");
	AST_OT: assert property ((fwd_travel_inhibit_open && rev_travel_inhibit_open)[*8] |-> alarm)
		else $error("no overtravel alarm");
	AST_ERR: assert property (psel && penable && paddr > spal_pkg::ADDR_DISC_LIM |-> pslverr) else $error("no slverr");
endmodule
bind spal_top spal_props chk_u (.clk_sys, .sys_rst, .psel, .penable, .paddr, .pslverr, .deviation_count,
	.scale_frame, .scale_frame_err, .scale_cable_ok, .nvm_check_done, .nvm_param_bad,
	.fwd_travel_inhibit_open, .rev_travel_inhibit_open, .alarm, .error_code, .run_enable);

// ### test/spal_plant.sv
// scale link and stored-data side model
`timescale 1ns/10ps
module spal_plant
(
	input  wire logic       clk_sys,
	input  wire logic       link_on,
	input  wire logic       inject_err,
	input  wire logic       nvm_go,
	input  wire logic [1:0] nvm_bad,
	output logic            scale_frame = 1'b0,
	output logic            scale_frame_err = 1'b0,
	output logic            scale_cable_ok,
	output logic            nvm_check_done = 1'b0,
	output logic            nvm_param_bad = 1'b0,
	output logic            nvm_code_bad = 1'b0
);
	logic [2:0] slot = 3'h0;
	logic       tog = 1'b0;
	assign scale_cable_ok = 1'b1;
	// qualifiers toggle outside their slot so a stale level is never trusted
	always @(posedge clk_sys)
	begin
		slot <= slot + 3'h1;
		tog <= !tog;
		scale_frame <= link_on && slot == 3'h7;
		scale_frame_err <= (link_on && slot == 3'h7) ? inject_err : tog;
		nvm_check_done <= nvm_go;
		nvm_param_bad <= nvm_go ? nvm_bad[0] : tog;
		nvm_code_bad <= nvm_go ? nvm_bad[1] : !tog;
	end
endmodule

// ### test/spal_top_test.sv
// self-checking bench for the protection alarm logic
`timescale 1ns/10ps
module spal_top_test;
	logic               clk_sys = 1'b0;
	logic               sys_rst = 1'b1;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic        [7:0]  paddr = 8'h00;
	logic        [31:0] pwdata = 32'h0;
	logic        [31:0] prdata;
	logic               pready, pslverr, last_err, alarm, run_enable, irq;
	logic signed [31:0] motor_pos = 32'sh0, scale_pos = 32'sh0, deviation_count = 32'sh0;
	logic        [31:0] motor_speed = 32'h0;
	logic               scale_frame, scale_frame_err, scale_cable_ok, nvm_check_done, nvm_param_bad, nvm_code_bad;
	logic               fwd_open = 1'b0, rev_open = 1'b0, link_on = 1'b1, inject_err = 1'b0, nvm_go = 1'b0;
	logic        [1:0]  nvm_bad = 2'h0;
	logic        [7:0]  error_code;
	int                 fail_count = 0, total_checks = 0;
	always #4 clk_sys = !clk_sys;
	spal_plant plant_u (.clk_sys(clk_sys), .link_on(link_on), .inject_err(inject_err), .nvm_go(nvm_go),
		.nvm_bad(nvm_bad), .scale_frame(scale_frame), .scale_frame_err(scale_frame_err),
		.scale_cable_ok(scale_cable_ok), .nvm_check_done(nvm_check_done), .nvm_param_bad(nvm_param_bad),
		.nvm_code_bad(nvm_code_bad));
	spal_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.motor_pos(motor_pos), .scale_pos(scale_pos), .motor_speed(motor_speed),
		.deviation_count(deviation_count), .scale_frame(scale_frame), .scale_frame_err(scale_frame_err),
		.scale_cable_ok(scale_cable_ok), .nvm_check_done(nvm_check_done), .nvm_param_bad(nvm_param_bad),
		.nvm_code_bad(nvm_code_bad), .fwd_travel_inhibit_open(fwd_open), .rev_travel_inhibit_open(rev_open),
		.alarm(alarm), .error_code(error_code), .run_enable(run_enable), .irq(irq));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (int n = 0; n < 20; n++)
		begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		check("pready", {31'h0, pready}, 32'h1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		check(what, q, exp);
	endtask
	task automatic quiet(input string what);
		repeat (10) @(posedge clk_sys);
		check(what, {31'h0, alarm}, 32'h0);
	endtask
	task automatic expect_alarm(input string what, input logic [7:0] code, input logic [31:0] st, input logic ir);
		for (int n = 0; n < 200 && alarm !== 1'b1; n++)
			@(posedge clk_sys);
		check(what, {24'h0, error_code}, {24'h0, code});
		check("run_enable", {31'h0, run_enable}, 32'h0);
		rd_chk("status", spal_pkg::ADDR_STATUS, st);
		check("irq", {31'h0, irq}, {31'h0, ir});
	endtask
	// fault must be gone for long enough to pass the input synchronisers
	task automatic recover(input string name, input logic [31:0] ctrl);
		repeat (16) @(posedge clk_sys);
		wr(spal_pkg::ADDR_CTRL, ctrl | (32'h1 << spal_pkg::CTRL_CLEAR));
		wr(spal_pkg::ADDR_STATUS, 32'h0000_03FF);
		repeat (2) @(posedge clk_sys);
		check("alarm", {31'h0, alarm}, 32'h0);
		check("run_enable", {31'h0, run_enable}, 32'h1);
		check("irq", {31'h0, irq}, 32'h0);
		$display("test %s done", name);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		fail_count++;
		$display("ERROR watchdog expired");
		tally_and_finish();
	end
	// ----
	// tests
	// ----
	initial
	begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd_chk("hyb limit", spal_pkg::ADDR_HYB_LIM, spal_pkg::HYB_LIM_RESET);
		rd_chk("disc limit", spal_pkg::ADDR_DISC_LIM, spal_pkg::DISC_LIM_RESET);
		rd_chk("unmapped", 8'h34, 32'h0);
		check("pslverr", {31'h0, last_err}, 32'h1);
		wr(spal_pkg::ADDR_MASK, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			wr(spal_pkg::ADDR_OVS_LVL, i ? 32'h0 : 32'h0000_0064);
			motor_speed <= i ? 32'h0000_1C20 : 32'h0000_0064;
			quiet("speed at level");
			motor_speed <= motor_speed + 32'h1;
			expect_alarm("overspeed", spal_pkg::ERR_OVS, 32'h2, 1'b1);
			motor_speed <= 32'h0;
			recover("overspeed", 32'h0);
		end
		deviation_count <= 32'sh0800_0000;
		quiet("deviation at limit");
		deviation_count <= -32'sh0800_0001;
		expect_alarm("deviation", spal_pkg::ERR_DOVF, 32'h10, 1'b1);
		deviation_count <= 32'sh0;
		recover("deviation", 32'h0);
		wr(spal_pkg::ADDR_MASK, 32'h0000_03FF);
		wr(spal_pkg::ADDR_GEAR2, 32'h0FA1_0001);
		expect_alarm("gear", spal_pkg::ERR_GEAR, 32'h4, 1'b0);
		wr(spal_pkg::ADDR_MASK, 32'h0);
		repeat (2) @(posedge clk_sys);
		check("irq unmasked", {31'h0, irq}, 32'h1);
		wr(spal_pkg::ADDR_GEAR2, spal_pkg::GEAR_RESET);
		recover("gear", 32'h0);
		inject_err <= 1'b1;
		expect_alarm("scale data", spal_pkg::ERR_SDAT, 32'h8, 1'b1);
		inject_err <= 1'b0;
		recover("scale data", 32'h0);
		wr(spal_pkg::ADDR_DISC_LIM, 32'h0000_0020);
		wr(spal_pkg::ADDR_CTRL, 32'h1);
		link_on <= 1'b0;
		expect_alarm("scale silent", spal_pkg::ERR_SDIS, 32'h40, 1'b1);
		link_on <= 1'b1;
		recover("scale silent", 32'h0);
		motor_pos <= 32'sh0000_2710;
		quiet("travel at limit");
		motor_pos <= 32'sh0000_2711;
		expect_alarm("travel", spal_pkg::ERR_SOFT, 32'h20, 1'b1);
		motor_pos <= 32'sh0000_1770;
		scale_pos <= -32'sh0000_0BB8;
		wr(spal_pkg::ADDR_SCL_NUM, 32'h0000_0004);
		wr(spal_pkg::ADDR_SCL_DEN, 32'h0000_0002);
		recover("travel", 32'h3);
		quiet("inverted scale");
		wr(spal_pkg::ADDR_CTRL, 32'h1);
		expect_alarm("hybrid", spal_pkg::ERR_HYB, 32'h1, 1'b1);
		scale_pos <= 32'sh0000_1770;
		recover("hybrid", 32'h0);
		for (int m = 0; m < 2; m++)
		begin
			wr(spal_pkg::ADDR_CTRL, m ? 32'h8 : 32'h0);
			fwd_open <= 1'b1;
			if (m == 0)
			begin
				quiet("one inhibit open");
				rev_open <= 1'b1;
			end
			expect_alarm("overtravel", spal_pkg::ERR_OT, 32'h200, 1'b1);
			fwd_open <= 1'b0;
			rev_open <= 1'b0;
			recover("overtravel", m ? 32'h8 : 32'h0);
		end
		nvm_bad <= 2'h3;
		nvm_go <= 1'b1;
		@(posedge clk_sys);
		nvm_go <= 1'b0;
		expect_alarm("stored data", spal_pkg::ERR_PARM, 32'h180, 1'b1);
		$display("test stored data done");
		tally_and_finish();
	end
endmodule
